/* File: dcso_cache_ctl.sv */
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module dcso_cache_ctl
  import dcso_pkg::*;
#(
  parameter int MISS_SLOTS = 2
)(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                op_valid,
  input  wire logic                op_port,
  input  wire dcso_op_type         op_code,
  input  wire dcso_mode_type       op_mode,
  input  wire logic [ADDR_W-1:0]   base_operand,
  input  wire logic [ADDR_W-1:0]   index_operand,
  input  wire logic [OFFSET_W-1:0] op_offset,
  input  wire logic [DATA_W-1:0]   store_data,
  output      logic                stall,
  output      logic                op_done,
  output      logic [DATA_W-1:0]   result_data,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output      logic [31:0]         reg_rdata,
  output      logic                wb_req,
  output      logic [ADDR_W-1:0]   wb_addr,
  input  wire logic                wb_ack,
  output      logic                fill_req,
  output      logic [ADDR_W-1:0]   fill_addr,
  output      logic                fill_id,
  input  wire logic                fill_ack,
  input  wire logic                fill_ack_id,
  output      logic                io_req,
  output      logic                io_we,
  output      logic [ADDR_W-1:0]   io_addr,
  output      logic [DATA_W-1:0]   io_wdata,
  input  wire logic                io_ack,
  input  wire logic [DATA_W-1:0]   io_rdata
);

  if (MISS_SLOTS < 1 || MISS_SLOTS > MISS_SLOTS_MAX) begin : g_bad_slots
    $error("MISS_SLOTS must be 1 or 2");
  end

  dcso_state_reg_type q_reg;
  dcso_state_reg_type q_next;

  ////////////////////////////////////////////////////////////////////////////////
  // address generation

  logic              disp_only;
  dcso_mode_type     gen_mode;
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-1:0] block_addr;

  assign disp_only = (op_code == OP_COPYBACK) || (op_code == OP_INVALIDATE) ||
                     (op_code == OP_RDTAG) || (op_code == OP_RDSTATUS);
  assign gen_mode  = disp_only ? MODE_DISP : op_mode;

  dcso_addr_gen u_addr_gen (
    .base_operand  (base_operand),
    .index_operand (index_operand),
    .op_offset     (op_offset),
    .mode          (gen_mode),
    .eff_addr      (eff_addr),
    .block_addr    (block_addr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] blk_idx(input logic [SET_W-1:0] set,
                                         input logic [WAY_W-1:0] way);
    blk_idx = {set, way};
  endfunction

  // lookup over one set; use_pending counts in-flight fills as present
  function automatic logic [WAY_W:0] find_way(input dcso_state_reg_type s,
                                              input logic [SET_W-1:0] set,
                                              input logic [TAG_W-1:0] tag,
                                              input logic use_pending);
    logic [7:0] i;
    find_way = '0;
    for (int w = 0; w < NWAYS; w++) begin
      i = blk_idx(set, WAY_W'(w));
      if ((s.valid[i] || (use_pending && s.pending[i])) && s.tag[i] == tag) begin
        find_way = {1'b1, WAY_W'(w)};
      end
    end
  endfunction

  // free way first, else the way the set marks as least recent, or the way after it if that one is pending
  function automatic logic [WAY_W-1:0] pick_victim(input dcso_state_reg_type s,
                                                   input logic [SET_W-1:0] set);
    logic [7:0] i;
    logic       found;
    pick_victim = s.lru[set][WAY_W-1:0];
    found       = 1'b0;
    for (int w = 0; w < NWAYS; w++) begin
      i = blk_idx(set, WAY_W'(w));
      if (!found && !s.valid[i] && !s.pending[i]) begin
        pick_victim = WAY_W'(w);
        found       = 1'b1;
      end
    end
    if (!found && s.pending[blk_idx(set, pick_victim)]) begin
      pick_victim = pick_victim + WAY_W'(1);
    end
  endfunction

  function automatic logic [LRU_W-1:0] touch_lru(input logic [LRU_W-1:0] l,
                                                 input logic [WAY_W-1:0] way);
    touch_lru = l;
    if (l[WAY_W-1:0] == way) begin
      touch_lru[WAY_W-1:0] = way + WAY_W'(1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic [SET_W-1:0] set_sel;
  logic [TAG_W-1:0] tag_sel;
  logic [WAY_W-1:0] way_direct;
  logic [WAY_W:0]   hit_vec;
  logic [WAY_W-1:0] victim;
  logic [7:0]       hit_i;
  logic [7:0]       vic_i;
  logic [7:0]       dir_i;
  logic             cacheable;
  logic             special;
  logic             accept;
  logic [1:0]       miss_count;
  logic             slot_free;
  logic             slot_pick;

  assign set_sel    = eff_addr[SET_LSB +: SET_W];
  assign tag_sel    = eff_addr[TAG_LSB +: TAG_W];
  assign way_direct = eff_addr[WAY_LSB +: WAY_W];
  assign cacheable  = (block_addr >= q_reg.cbase) && (block_addr < q_reg.climit);
  assign special    = (op_code >= OP_COPYBACK);
  // new operations only in ST_IDLE, in issue order; loads and stores still in the pipe overlap later ones
  assign accept     = op_valid && (q_reg.st == ST_IDLE) && (!special || op_port);
  assign miss_count = 2'(q_reg.slot_busy[0]) + 2'(q_reg.slot_busy[1]);
  assign slot_free  = (miss_count < 2'(MISS_SLOTS));
  assign slot_pick  = q_reg.slot_busy[0];
  assign victim     = pick_victim(q_reg, set_sel);
  assign vic_i      = blk_idx(set_sel, victim);
  assign dir_i      = blk_idx(set_sel, way_direct);

  always_comb begin
    hit_vec = find_way(q_reg, set_sel, tag_sel, op_code == OP_PREFETCH);
    hit_i   = blk_idx(set_sel, hit_vec[WAY_W-1:0]);
    q_next  = q_reg;
    q_next.wb_req   = 1'b0;
    q_next.fill_req = 1'b0;
    q_next.pipe_v   = {q_reg.pipe_v[LDST_LATENCY-2:0], 1'b0};
    q_next.pipe_d   = {q_reg.pipe_d[LDST_LATENCY-2:0], {DATA_W{1'b0}}};

    // register port
    if (reg_wr) begin
      case (reg_addr)
        REG_CBASE:  q_next.cbase  = reg_wdata;
        REG_CLIMIT: q_next.climit = reg_wdata;
        default:    q_next.cbase  = q_reg.cbase;
      endcase
    end
    q_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CBASE:  q_next.rdata = q_reg.cbase;
        REG_CLIMIT: q_next.rdata = q_reg.climit;
        REG_STATUS: q_next.rdata = {26'h0, miss_count, q_reg.slot_busy, q_reg.st};
        REG_DROPS:  q_next.rdata = {16'h0, q_reg.drops};
        default:    q_next.rdata = '0;
      endcase
    end

    // background fill completion
    for (int s = 0; s < MISS_SLOTS; s++) begin
      if (fill_ack && q_reg.slot_busy[s] && fill_ack_id == 1'(s)) begin
        q_next.slot_busy[s]                 = 1'b0;
        q_next.valid[q_reg.slot_blk[s]]     = 1'b1;
        q_next.pending[q_reg.slot_blk[s]]   = 1'b0;
      end
    end

    case (q_reg.st)
      ST_IDLE: begin
        if (accept) begin
          q_next.cnt = '0;
          case (op_code)
            OP_LOAD, OP_STORE: begin
              if (hit_vec[WAY_W]) begin
                q_next.lru[set_sel] = touch_lru(q_reg.lru[set_sel], hit_vec[WAY_W-1:0]);
                if (op_code == OP_STORE) begin
                  q_next.dirty[hit_i] = 1'b1;
                end
              end
              q_next.pipe_v[0] = 1'b1;
            end
            OP_UNCACHED_LOAD, OP_UNCACHED_STORE: begin
              q_next.io_req   = 1'b1;
              q_next.io_we    = (op_code == OP_UNCACHED_STORE);
              q_next.io_addr  = eff_addr;
              q_next.io_wdata = store_data;
              q_next.st       = ST_IO_WAIT;
            end
            OP_COPYBACK: begin
              if (hit_vec[WAY_W]) begin
                q_next.lru[set_sel][WAY_W-1:0] = hit_vec[WAY_W-1:0];
                if (q_reg.dirty[hit_i]) begin
                  q_next.wb_req       = 1'b1;
                  q_next.wb_addr      = block_addr;
                  q_next.wb_seen      = 1'b0;
                  q_next.dirty[hit_i] = 1'b0;
                  q_next.cnt          = STALL_CB_DIRTY_MIN;
                  q_next.st           = ST_WRITEBACK;
                end else begin
                  q_next.cnt = STALL_CB_CLEAN;
                  q_next.st  = ST_COUNT;
                end
              end
            end
            OP_INVALIDATE: begin
              if (hit_vec[WAY_W]) begin
                q_next.valid[hit_i] = 1'b0;
                q_next.dirty[hit_i] = 1'b0;
                q_next.lru[set_sel][WAY_W-1:0] = hit_vec[WAY_W-1:0];
                q_next.cnt = STALL_INV_HIT;
                q_next.st  = ST_COUNT;
              end
            end
            OP_RDTAG: begin
              q_next.pipe_v[0] = 1'b1;
              q_next.pipe_d[0] = '0;
              q_next.pipe_d[0][RDTAG_TAG_LSB +: TAG_W] = q_reg.tag[dir_i];
              q_next.pipe_d[0][RDTAG_VALID_BIT]        = q_reg.valid[dir_i];
            end
            OP_RDSTATUS: begin
              q_next.pipe_v[0] = 1'b1;
              q_next.pipe_d[0] = '0;
              for (int w = 0; w < NWAYS; w++) begin
                q_next.pipe_d[0][RDSTAT_DIRTY_LSB + w] =
                  q_reg.dirty[blk_idx(set_sel, WAY_W'(w))];
              end
              q_next.pipe_d[0][RDSTAT_LRU_LSB +: LRU_W] = q_reg.lru[set_sel];
              q_next.cnt = STALL_STATUS;
              q_next.st  = ST_COUNT;
            end
            OP_ALLOC: begin
              if (cacheable) begin
                if (hit_vec[WAY_W]) begin
                  q_next.lru[set_sel] = touch_lru(q_reg.lru[set_sel], hit_vec[WAY_W-1:0]);
                  q_next.cnt = STALL_ALLOC_CLEAN;
                  q_next.st  = ST_COUNT;
                end else begin
                  if (q_reg.valid[vic_i] && q_reg.dirty[vic_i]) begin
                    q_next.wb_req  = 1'b1;
                    q_next.wb_addr = {q_reg.tag[vic_i], set_sel, 6'h00};
                    q_next.wb_seen = 1'b0;
                    q_next.cnt     = STALL_EVICT_MIN;
                    q_next.st      = ST_WRITEBACK;
                  end else begin
                    q_next.cnt = STALL_ALLOC_CLEAN;
                    q_next.st  = ST_COUNT;
                  end
                  q_next.tag[vic_i]   = tag_sel;
                  q_next.valid[vic_i] = 1'b1;
                  q_next.dirty[vic_i] = 1'b0;
                  q_next.lru[set_sel] = touch_lru(q_reg.lru[set_sel], victim);
                end
              end
            end
            OP_PREFETCH: begin
              if (!cacheable) begin
                q_next.cnt = '0;
              end else if (hit_vec[WAY_W]) begin
                q_next.cnt = STALL_PREFETCH;
                q_next.st  = ST_COUNT;
              end else if (!slot_free) begin
                q_next.drops = q_reg.drops + 16'h0001;
              end else begin
                if (q_reg.valid[vic_i] && q_reg.dirty[vic_i]) begin
                  q_next.wb_req  = 1'b1;
                  q_next.wb_addr = {q_reg.tag[vic_i], set_sel, 6'h00};
                  q_next.wb_seen = 1'b0;
                  q_next.cnt     = STALL_EVICT_MIN;
                  q_next.st      = ST_WRITEBACK;
                end else begin
                  q_next.cnt = STALL_PREFETCH;
                  q_next.st  = ST_COUNT;
                end
                q_next.tag[vic_i]           = tag_sel;
                q_next.valid[vic_i]         = 1'b0;
                q_next.dirty[vic_i]         = 1'b0;
                q_next.pending[vic_i]       = 1'b1;
                q_next.lru[set_sel]         = touch_lru(q_reg.lru[set_sel], victim);
                q_next.slot_busy[slot_pick] = 1'b1;
                q_next.slot_blk[slot_pick]  = vic_i;
                q_next.fill_req             = 1'b1;
                q_next.fill_addr            = block_addr;
                q_next.fill_id              = slot_pick;
              end
            end
            default: q_next.cnt = '0;
          endcase
        end
      end
      ST_COUNT: begin
        q_next.cnt = q_reg.cnt - 5'h01;
        if (q_reg.cnt <= 5'h01) begin
          q_next.st = ST_IDLE;
        end
      end
      ST_WRITEBACK: begin
        if (wb_ack) begin
          q_next.wb_seen = 1'b1;
        end
        if (q_reg.cnt > 5'h01) begin
          q_next.cnt = q_reg.cnt - 5'h01;
        end
        // held until both the minimum count and the memory ack are in
        if (q_reg.cnt <= 5'h01 && (q_reg.wb_seen || wb_ack)) begin
          q_next.st = ST_IDLE;
        end
      end
      ST_IO_WAIT: begin
        if (io_ack) begin
          q_next.io_req    = 1'b0;
          q_next.pipe_v[0] = 1'b1;
          q_next.pipe_d[0] = q_reg.io_we ? '0 : io_rdata;
          q_next.st        = ST_IDLE;
        end
      end
      default: q_next.st = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_reg        <= '0;
      q_reg.st     <= ST_IDLE;
      q_reg.climit <= CLIMIT_RESET;
      q_reg.cbase  <= CBASE_RESET;
      for (int s = 0; s < NSETS; s++) begin
        q_reg.lru[s] <= LRU_RESET;
      end
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign stall       = (q_reg.st != ST_IDLE);
  assign op_done     = q_reg.pipe_v[LDST_LATENCY-1];
  assign result_data = q_reg.pipe_d[LDST_LATENCY-1];
  assign reg_rdata   = q_reg.rdata;
  assign wb_req      = q_reg.wb_req;
  assign wb_addr     = q_reg.wb_addr;
  assign fill_req    = q_reg.fill_req;
  assign fill_addr   = q_reg.fill_addr;
  assign fill_id     = q_reg.fill_id;
  assign io_req      = q_reg.io_req;
  assign io_we       = q_reg.io_we;
  assign io_addr     = q_reg.io_addr;
  assign io_wdata    = q_reg.io_wdata;

endmodule // dcso_cache_ctl

/* File: dcso_pkg.sv */
package dcso_pkg;

  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int SET_LSB     = 6;
  localparam int SET_W       = 5;
  localparam int WAY_LSB     = 11;
  localparam int WAY_W       = 3;
  localparam int TAG_LSB     = 11;
  localparam int TAG_W       = 21;
  localparam int NSETS       = 32;
  localparam int NWAYS       = 8;
  localparam int NBLK        = 256;
  localparam int LRU_W       = 10;
  localparam int OFFSET_W    = 7;
  localparam int MISS_SLOTS_MAX = 2;

  localparam logic [ADDR_W-1:0] BLOCK_MASK = 32'hffff_ffc0;

  // stall figures in core cycles
  localparam logic [4:0] STALL_CB_CLEAN     = 5'h04;
  localparam logic [4:0] STALL_CB_DIRTY_MIN = 5'h13;
  localparam logic [4:0] STALL_INV_HIT      = 5'h02;
  localparam logic [4:0] STALL_STATUS       = 5'h01;
  localparam logic [4:0] STALL_ALLOC_CLEAN  = 5'h03;
  localparam logic [4:0] STALL_PREFETCH     = 5'h03;
  localparam logic [4:0] STALL_EVICT_MIN    = 5'h0b;
  localparam int         LDST_LATENCY       = 3;

  // register map
  localparam logic [7:0] REG_CBASE  = 8'h00;
  localparam logic [7:0] REG_CLIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DROPS  = 8'h0c;

  localparam logic [31:0] CBASE_RESET  = 32'h0000_0000;
  localparam logic [31:0] CLIMIT_RESET = 32'h0100_0000;
  localparam logic [LRU_W-1:0] LRU_RESET = 10'h000;

  // result word layout
  localparam int RDTAG_VALID_BIT  = 0;
  localparam int RDTAG_TAG_LSB    = 11;
  localparam int RDSTAT_DIRTY_LSB = 0;
  localparam int RDSTAT_LRU_LSB   = 8;

  typedef enum logic [3:0] {
    OP_NONE          = 4'h0,
    OP_LOAD          = 4'h1,
    OP_STORE         = 4'h2,
    OP_UNCACHED_LOAD = 4'h3,
    OP_UNCACHED_STORE = 4'h4,
    OP_COPYBACK      = 4'h5,
    OP_INVALIDATE    = 4'h6,
    OP_RDTAG         = 4'h7,
    OP_RDSTATUS      = 4'h8,
    OP_ALLOC         = 4'h9,
    OP_PREFETCH      = 4'ha
  } dcso_op_type;

  typedef enum logic [1:0] {
    MODE_DISP            = 2'h0,
    MODE_INDEX           = 2'h1,
    MODE_HALFWORD_SCALED = 2'h2,
    MODE_WORD_SCALED     = 2'h3
  } dcso_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_COUNT     = 2'b01,
    ST_WRITEBACK = 2'b11,
    ST_IO_WAIT   = 2'b10
  } dcso_state_type;

  typedef struct packed {
    logic [NBLK-1:0][TAG_W-1:0]   tag;
    logic [NBLK-1:0]              valid;
    logic [NBLK-1:0]              dirty;
    logic [NBLK-1:0]              pending;
    logic [NSETS-1:0][LRU_W-1:0]  lru;
    dcso_state_type               st;
    logic [4:0]                   cnt;
    logic                         wb_seen;
    logic                         wb_req;
    logic [ADDR_W-1:0]            wb_addr;
    logic                         fill_req;
    logic [ADDR_W-1:0]            fill_addr;
    logic                         fill_id;
    logic [1:0]                   slot_busy;
    logic [1:0][7:0]              slot_blk;
    logic                         io_req;
    logic                         io_we;
    logic [ADDR_W-1:0]            io_addr;
    logic [DATA_W-1:0]            io_wdata;
    logic [LDST_LATENCY-1:0]      pipe_v;
    logic [LDST_LATENCY-1:0][DATA_W-1:0] pipe_d;
    logic [31:0]                  cbase;
    logic [31:0]                  climit;
    logic [15:0]                  drops;
    logic [DATA_W-1:0]            rdata;
  } dcso_state_reg_type;

endpackage

/* File: dcso_addr_gen.sv */
`timescale 1ns/1ps
module dcso_addr_gen
  import dcso_pkg::*;
(
  input  wire logic [ADDR_W-1:0]   base_operand,
  input  wire logic [ADDR_W-1:0]   index_operand,
  input  wire logic [OFFSET_W-1:0] op_offset,
  input  wire dcso_mode_type       mode,
  output      logic [ADDR_W-1:0]   eff_addr,
  output      logic [ADDR_W-1:0]   block_addr
);

  logic [ADDR_W-1:0] disp_bytes;

  // seven-bit offset counts words: -256..252 bytes
  assign disp_bytes = {{(ADDR_W-OFFSET_W-2){op_offset[OFFSET_W-1]}}, op_offset, 2'b00};

  always_comb begin
    case (mode)
      MODE_DISP:            eff_addr = base_operand + disp_bytes;
      MODE_INDEX:           eff_addr = base_operand + index_operand;
      MODE_HALFWORD_SCALED: eff_addr = base_operand + {index_operand[ADDR_W-2:0], 1'b0};
      MODE_WORD_SCALED:     eff_addr = base_operand + {index_operand[ADDR_W-3:0], 2'b00};
      default:              eff_addr = base_operand;
    endcase
  end

  assign block_addr = eff_addr & BLOCK_MASK;

endmodule // dcso_addr_gen

/* File: dcso_mem_model.sv */
`timescale 1ns/1ps
module dcso_mem_model
  import dcso_pkg::*;
#(
  parameter int          WB_DLY   = 22,
  parameter int          FILL_DLY = 60,
  parameter logic [31:0] IO_DATA  = 32'h5a3c_0f96
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        wb_req,
  input  wire logic        fill_req,
  input  wire logic        fill_id,
  input  wire logic        io_req,
  output      logic        wb_ack,
  output      logic        fill_ack,
  output      logic        fill_ack_id,
  output      logic        io_ack,
  output      logic [31:0] io_rdata
);
  int   wb_cnt, io_cnt, f0_cnt, f1_cnt;
  logic io_seen;
  // slot one waits a cycle when both fills finish together
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {wb_cnt, io_cnt, f0_cnt, f1_cnt, io_seen} <= '0;
      {wb_ack, fill_ack, fill_ack_id, io_ack, io_rdata} <= '0;
    end else begin
      wb_ack <= wb_cnt == 1;
      wb_cnt <= wb_req ? WB_DLY : wb_cnt - (wb_cnt > 0);
      io_seen <= io_req;
      io_ack <= io_cnt == 1;
      io_cnt <= (io_req && !io_seen) ? 4 : io_cnt - (io_cnt > 0);
      io_rdata <= io_cnt == 1 ? IO_DATA : ~io_rdata;
      fill_ack <= f0_cnt == 1 || f1_cnt == 1;
      fill_ack_id <= f0_cnt != 1;
      f0_cnt <= (fill_req && !fill_id) ? FILL_DLY : f0_cnt - (f0_cnt > 0);
      f1_cnt <= (fill_req && fill_id) ? FILL_DLY
                : f1_cnt - (f1_cnt > 1 || (f1_cnt == 1 && f0_cnt != 1));
    end
  end
endmodule // dcso_mem_model

/* File: dcso_cache_ctl_props.sv */
`timescale 1ns/1ps
module dcso_cache_ctl_props
  import dcso_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        op_valid,
  input wire logic        op_port,
  input wire dcso_op_type op_code,
  input wire logic        stall,
  input wire logic        op_done,
  input wire logic        io_req,
  input wire logic        io_ack
);
  logic        taken;
  logic [5:0]  run_reg;
  dcso_op_type last_reg;
  assign taken = ce && op_valid && !stall && (op_code < OP_COPYBACK || op_port);
  // length of the stall run that just ended, and the op behind it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_reg <= 6'h00;
      last_reg <= OP_NONE;
    end else begin
      run_reg <= stall ? run_reg + 6'h01 : 6'h00;
      last_reg <= taken ? op_code : last_reg;
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence one_stall;
    stall ##1 !stall;
  endsequence
  AST_RDTAG_NO_STALL: assert property (taken && op_code == OP_RDTAG |=> !stall)
    else $error("rdtag stalled");
  AST_RDSTAT_STALL: assert property (taken && op_code == OP_RDSTATUS |=> one_stall)
    else $error("rdstatus stall not one cycle");
  AST_LDST_LAT: assert property (taken && op_code inside {OP_LOAD, OP_STORE} |-> ##3 op_done)
    else $error("load or store latency wrong");
  AST_PORT0_IGNORED: assert property (op_valid && !stall && !op_port
    && op_code >= OP_COPYBACK |=> !stall) else $error("first port ran a maintenance op");
  AST_INV_STALL: assert property ($fell(stall) && last_reg == OP_INVALIDATE |-> run_reg == 6'h02)
    else $error("invalidate stall wrong");
  AST_CB_STALL: assert property ($fell(stall) && last_reg == OP_COPYBACK
    |-> run_reg == 6'h04 || run_reg >= 6'h13) else $error("copyback stall wrong");
  AST_PREF_STALL: assert property ($fell(stall) && last_reg == OP_PREFETCH
    |-> run_reg == 6'h03 || run_reg >= 6'h0b) else $error("prefetch stall wrong");
  AST_IO_STALL: assert property (io_req && !io_ack && !$past(io_ack) |-> stall)
    else $error("core released during uncached access");
endmodule // dcso_cache_ctl_props

bind dcso_cache_ctl dcso_cache_ctl_props u_props (.ref_clk, .rst, .ce, .op_valid, .op_port,
  .op_code, .stall, .op_done, .io_req, .io_ack);

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import dcso_pkg::*;
;
  localparam logic [31:0] IO_DATA = 32'h5a3c_0f96;
  logic          ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, op_valid = 1'b0, op_port = 1'b0;
  logic          reg_wr = 1'b0, reg_rd = 1'b0;
  dcso_op_type   op_code = OP_NONE;
  dcso_mode_type op_mode = MODE_DISP;
  logic [31:0]   base_operand = '0, index_operand = '0, store_data = '0, reg_wdata = '0;
  logic [6:0]    op_offset = '0;
  logic [7:0]    reg_addr = '0;
  logic [31:0]   last_wb = '0, last_fill = '0;
  logic          stall, op_done, wb_req, wb_ack, fill_req, fill_id, fill_ack, fill_ack_id;
  logic          io_req, io_we, io_ack;
  logic [31:0]   result_data, reg_rdata, wb_addr, fill_addr, io_addr, io_wdata, io_rdata;
  int            err_total = 0, samples_checked = 0;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (wb_req) last_wb <= wb_addr;
    if (fill_req) last_fill <= fill_addr;
  end
  dcso_cache_ctl dut (.ref_clk, .rst, .ce, .op_valid, .op_port, .op_code, .op_mode, .base_operand,
    .index_operand, .op_offset, .store_data, .stall, .op_done, .result_data, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wb_req, .wb_addr, .wb_ack, .fill_req,
    .fill_addr, .fill_id, .fill_ack, .fill_ack_id, .io_req, .io_we, .io_addr, .io_wdata,
    .io_ack, .io_rdata);
  dcso_mem_model #(.IO_DATA(IO_DATA)) mem (.ref_clk, .rst, .wb_req, .fill_req, .fill_id,
    .io_req, .wb_ack, .fill_ack, .fill_ack_id, .io_ack, .io_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(negedge ref_clk);
    if (!w) check("reg", d, reg_rdata);
  endtask
  // issue one op, hold it until taken, then count stall cycles
  task automatic op(input dcso_op_type c, input logic p, input dcso_mode_type m,
    input logic [31:0] b, input logic [31:0] ix, input logic [6:0] off, input int exp,
    input logic atl);
    int n;
    n = 0;
    @(posedge ref_clk);
    {op_valid, op_port} <= {1'b1, p};
    op_code <= c;
    op_mode <= m;
    {base_operand, index_operand, op_offset} <= {b, ix, off};
    @(negedge ref_clk);
    while (stall !== 1'b0) @(negedge ref_clk);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    @(negedge ref_clk);
    while (stall === 1'b1 && n < 200) begin
      n++;
      @(negedge ref_clk);
    end
    check("stall", 32'(exp), (atl && n >= exp) ? 32'(exp) : 32'(n));
  endtask
  task automatic result(input logic [31:0] mask, input logic [31:0] exp);
    int n;
    n = 0;
    while (op_done !== 1'b1 && n < 12) begin
      n++;
      @(negedge ref_clk);
    end
    check("done", 32'h1, {31'h0, op_done});
    check("data", exp, result_data & mask);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    reg_io(1'b0, REG_CLIMIT, CLIMIT_RESET);
    reg_io(1'b0, 8'h10, 32'h0);
    reg_io(1'b1, REG_CLIMIT, 32'h0080_0000);
    reg_io(1'b0, REG_CLIMIT, 32'h0080_0000);
    op(OP_ALLOC, 1'b1, MODE_WORD_SCALED, 32'h1000, 32'h10, 7'h00, 3, 1'b0);
    op(OP_INVALIDATE, 1'b0, MODE_DISP, 32'h1040, 32'h0, 7'h00, 0, 1'b0);
    op(OP_PREFETCH, 1'b1, MODE_DISP, 32'h1000, 32'h0, 7'h10, 3, 1'b0);
    check("fill", 32'h0, last_fill);
    op(OP_RDTAG, 1'b1, MODE_DISP, 32'h0008_0044, 32'h0, 7'h7f, 0, 1'b0);
    result(32'hffff_ffff, 32'h0000_1001);
    op(OP_STORE, 1'b1, MODE_DISP, 32'h1040, 32'h0, 7'h00, 0, 1'b0);
    result(32'hffff_ffff, 32'h0);
    op(OP_LOAD, 1'b0, MODE_DISP, 32'h1040, 32'h0, 7'h00, 0, 1'b0);
    result(32'hffff_ffff, 32'h0);
    op(OP_RDSTATUS, 1'b1, MODE_DISP, 32'h3840, 32'h0, 7'h00, 1, 1'b0);
    result(32'h3_ffff, 32'h0_0101);
    op(OP_COPYBACK, 1'b1, MODE_DISP, 32'h1040, 32'h0, 7'h00, 19, 1'b1);
    check("wb addr", 32'h1040, last_wb);
    op(OP_RDSTATUS, 1'b1, MODE_DISP, 32'h40, 32'h0, 7'h00, 1, 1'b0);
    result(32'h3_ffff, 32'h0);
    op(OP_COPYBACK, 1'b1, MODE_DISP, 32'h1040, 32'h0, 7'h00, 4, 1'b0);
    op(OP_COPYBACK, 1'b1, MODE_DISP, 32'h9000, 32'h0, 7'h00, 0, 1'b0);
    op(OP_INVALIDATE, 1'b1, MODE_DISP, 32'h1040, 32'h0, 7'h00, 2, 1'b0);
    op(OP_RDTAG, 1'b1, MODE_DISP, 32'h40, 32'h0, 7'h00, 0, 1'b0);
    result(32'h1, 32'h0);
    op(OP_INVALIDATE, 1'b1, MODE_DISP, 32'h1040, 32'h0, 7'h00, 0, 1'b0);
    op(OP_PREFETCH, 1'b1, MODE_HALFWORD_SCALED, 32'h2000, 32'h20, 7'h00, 3, 1'b0);
    check("fill", 32'h2040, last_fill);
    op(OP_PREFETCH, 1'b1, MODE_INDEX, 32'h3000, 32'h7f, 7'h00, 3, 1'b0);
    check("fill", 32'h3040, last_fill);
    check("fill id", 32'h1, {31'h0, fill_id});
    op(OP_PREFETCH, 1'b1, MODE_DISP, 32'h4000, 32'h0, 7'h10, 0, 1'b0);
    check("fill", 32'h3040, last_fill);
    reg_io(1'b0, REG_DROPS, 32'h1);
    reg_io(1'b0, REG_STATUS, 32'h2c);
    op(OP_ALLOC, 1'b1, MODE_INDEX, 32'h0090_0000, 32'h40, 7'h00, 0, 1'b0);
    op(OP_UNCACHED_LOAD, 1'b0, MODE_DISP, 32'h0100_0000, 32'h0, 7'h00, 1, 1'b1);
    result(32'hffff_ffff, IO_DATA);
    @(posedge ref_clk) store_data <= 32'hc3c3_0001;
    op(OP_UNCACHED_STORE, 1'b0, MODE_DISP, 32'h0100_0040, 32'h0, 7'h00, 1, 1'b1);
    check("io we", 32'h1, {31'h0, io_we});
    check("io addr", 32'h0100_0040, io_addr);
    check("io data", 32'hc3c3_0001, io_wdata);
    result(32'hffff_ffff, 32'h0);
    end_sim();
  end
endmodule // tb_top
